// ---- common/pscec_consts.vh ----
// constants of the phy special control and error counter register bank
`ifndef PSCEC_CONSTS_VH
`define PSCEC_CONSTS_VH

// ----------------------------------------------------------------------------
// register numbers on the management interface
// ----------------------------------------------------------------------------
`define PSCEC_REG_CTRL       5'h11
`define PSCEC_REG_ADDR       5'h12
`define PSCEC_REG_FALSE_CAR  5'h13
`define PSCEC_REG_DISCON     5'h14
`define PSCEC_REG_ERR_FRAME  5'h15
`define PSCEC_REG_SYM_ERR    5'h16
`define PSCEC_REG_PREM_EOF   5'h17
`define PSCEC_REG_TEN_EOF    5'h18
`define PSCEC_REG_JABBER     5'h19
`define PSCEC_REG_EQUALIZER  5'h1a

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define PSCEC_BIT_SCRAMBLER_BYPASS  15
`define PSCEC_BIT_CODING_BYPASS     14
`define PSCEC_BIT_FORCE_H_PATTERN   13
`define PSCEC_BIT_FORCE_34_PATTERN  12
`define PSCEC_BIT_GOOD_LINK         11
`define PSCEC_BIT_RESERVED          10
`define PSCEC_BIT_TX_CRS_DISABLE    9
`define PSCEC_BIT_DYN_PD_DISABLE    8
`define PSCEC_BIT_AN_LOOPBACK       7
`define PSCEC_BIT_MDI_TRISTATE      6
`define PSCEC_BIT_FILTER_BYPASS     5
`define PSCEC_BIT_AUTO_POL_DISABLE  4
`define PSCEC_BIT_SQUELCH_DISABLE   3
`define PSCEC_BIT_EXT_SQUELCH       2
`define PSCEC_BIT_LINK_INT_DISABLE  1
`define PSCEC_BIT_JABBER_DISABLE    0

// ----------------------------------------------------------------------------
// reset values and widths
// ----------------------------------------------------------------------------
`define PSCEC_CTRL_RESET      16'h0000
`define PSCEC_CTRL_WR_MASK    16'hfbff
`define PSCEC_PHY_ADDR_VALUE  5'h01
`define PSCEC_PHY_ADDR_PAD    11'h000
`define PSCEC_CNT_ZERO        16'h0000
`define PSCEC_CNT_ONE         16'h0001
`define PSCEC_CNT_FULL        16'hffff
`define PSCEC_JABBER_RESET    16'h0001
`define PSCEC_EQ_RESET        16'h0000
`define PSCEC_DATA_ZERO       16'h0000
`define PSCEC_NUM_COUNTERS    7
`define PSCEC_SYM_RUN_LEN     3'h6
`define PSCEC_SYM_RUN_ZERO    3'h0
`define PSCEC_SYM_RUN_ONE     3'h1

`endif

// ---- hdl/pscec_sat_counter.v ----
// saturating clear-on-read event counter
`timescale 1ns/100ps
module pscec_sat_counter #(
    parameter [15:0] RESET_VALUE = 16'h0000
) (
    input  wire        clk_sys_in,
    input  wire        arst_n_in,
    input  wire        event_in,
    input  wire        clear_in,
    output reg  [15:0] count_out
);
`include "pscec_consts.vh"

    reg [15:0] next_count;

    // ------------------------------------------------------------------------
    // next value
    // ------------------------------------------------------------------------
    // a clear that meets an event restarts at one so the event is kept
    always @* begin
        if (clear_in) begin
            next_count = event_in ? `PSCEC_CNT_ONE : `PSCEC_CNT_ZERO;
        end else if (event_in && (count_out != `PSCEC_CNT_FULL)) begin
            next_count = count_out + `PSCEC_CNT_ONE;
        end else begin
            next_count = count_out; // freezes at full scale
        end
    end

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            count_out <= RESET_VALUE;
        end else begin
            count_out <= next_count;
        end
    end
endmodule

// ---- hdl/pscec_sync.v ----
// two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/100ps
module pscec_sync #(
    parameter WIDTH = 7
) (
    input  wire             clk_sys_in,
    input  wire             arst_n_in,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta;

    // ------------------------------------------------------------------------
    // two stages; the first is read only by the second
    // ------------------------------------------------------------------------
    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            meta     <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// ---- hdl/pscec_top.v ----
// phy special control register and receive/transmit error counter bank
//
// How it works
// - control bit 15 set bypasses the scrambler; resets to zero.
// - control bit 14 set bypasses four-to-five bit symbol coding.
// - bit 13 forces H test pattern, bit 12 forces 34 pattern.
// - bit 11 set forces the 100BASE-TX link to be treated good.
// - bit 9 set disables transmit carrier sense.
// - bit 8 set disables dynamic power-down; reset leaves it enabled.
// - bit 7 set puts auto-negotiation into loopback.
// - bit 6 set tri-states the line transmit driver.
// - bit 5 set bypasses the receive filter.
// - bit 4 set disables automatic polarity correction.
// - bit 3 set disables the 10BASE-T squelch test.
// - bit 2 set enables extended 10BASE-T squelch.
// - bit 1 disables link integrity, bit 0 disables jabber.
// - reserved bit 10 resets to zero and is kept zero.
// - address register reads fixed address in bits 4:0, zero above.
// - false carrier events counted, 16 bits, cleared by read.
// - disconnect events counted, saturating, cleared by read.
// - error frames counted at most once per frame, saturating.
// - symbol errors counted; six consecutive bad symbols count once.
// - premature end-of-frame events counted, saturating, cleared by read.
// - 10BASE-T end-of-frame errors counted, saturating, cleared by read.
// - jabber detections counted, saturating, cleared by read, reset one.
`timescale 1ns/100ps
module pscec_top (
    input  wire        clk_sys_in,
    input  wire        arst_n_in,
    // management register port
    input  wire        mgmt_rd_in,
    input  wire        mgmt_wr_in,
    input  wire [4:0]  mgmt_reg_in,
    input  wire [15:0] mgmt_wdata_in,
    output reg  [15:0] mgmt_rdata_out,
    output reg         mgmt_rvalid_out,
    // events from the receive and transmit datapaths (may be asynchronous)
    input  wire        false_carrier_in,
    input  wire        disconnect_in,
    input  wire        rx_frame_active_in,
    input  wire        rx_symbol_error_in,
    input  wire        premature_eof_in,
    input  wire        ten_eof_error_in,
    input  wire        jabber_detect_in,
    // controls to the coding and analog datapaths
    output reg         scrambler_bypass_out,
    output reg         coding_bypass_out,
    output reg         force_h_pattern_out,
    output reg         force_34_pattern_out,
    output reg         force_good_link_out,
    output reg         tx_crs_disable_out,
    output reg         dyn_power_down_disable_out,
    output reg         an_loopback_out,
    output reg         mdi_tristate_out,
    output reg         filter_bypass_out,
    output reg         auto_polarity_disable_out,
    output reg         squelch_disable_out,
    output reg         ext_squelch_out,
    output reg         link_integrity_disable_out,
    output reg         jabber_disable_out,
    output reg  [15:0] equalizer_ctrl_out
);
`include "pscec_consts.vh"

    // ------------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------------
    localparam CNT_FALSE = 0;
    localparam CNT_DISC  = 1;
    localparam CNT_FRAME = 2;
    localparam CNT_SYM   = 3;
    localparam CNT_PREM  = 4;
    localparam CNT_TEN   = 5;
    localparam CNT_JAB   = 6;

    // frame tracking states for the error frame counter
    localparam [0:0] FRM_CLEAN  = 1'b0;
    localparam [0:0] FRM_MARKED = 1'b1;

    reg  [15:0] ctrl;
    reg  [15:0] equalizer;
    reg  [15:0] next_rdata;
    reg  [0:0]  frm_state;
    reg  [0:0]  next_frm_state;
    reg  [2:0]  sym_run;
    reg  [2:0]  next_sym_run;
    reg  [6:0]  evt_prev;
    reg         frame_event;
    reg         sym_event;

    wire [6:0]  evt_sync;
    wire [6:0]  evt_rise;
    wire [6:0]  cnt_event;
    wire [6:0]  cnt_clear;
    wire [15:0] cnt_value [0:`PSCEC_NUM_COUNTERS-1];

    // decode of a register number, shared by write and clear logic
    function sel;
        input [4:0] reg_num;
        input [4:0] target;
        begin
            sel = (reg_num == target);
        end
    endfunction

    // register number that clears each counter on read
    function [4:0] cnt_reg;
        input integer idx;
        begin
            case (idx)
                CNT_FALSE: cnt_reg = `PSCEC_REG_FALSE_CAR;
                CNT_DISC:  cnt_reg = `PSCEC_REG_DISCON;
                CNT_FRAME: cnt_reg = `PSCEC_REG_ERR_FRAME;
                CNT_SYM:   cnt_reg = `PSCEC_REG_SYM_ERR;
                CNT_PREM:  cnt_reg = `PSCEC_REG_PREM_EOF;
                CNT_TEN:   cnt_reg = `PSCEC_REG_TEN_EOF;
                default:   cnt_reg = `PSCEC_REG_JABBER;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------------
    // synchronise the event lines
    // ------------------------------------------------------------------------
    // datapath events may come from other clocks, so all pass two flops
    pscec_sync #(
        .WIDTH (7)
    ) u_sync (
        .clk_sys_in (clk_sys_in),
        .arst_n_in  (arst_n_in),
        .async_in   ({jabber_detect_in, ten_eof_error_in, premature_eof_in,
                      rx_symbol_error_in, rx_frame_active_in, disconnect_in,
                      false_carrier_in}),
        .sync_out   (evt_sync)
    );

    // edge detect on synchronised levels; one count per assertion
    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            evt_prev <= 7'h00;
        end else begin
            evt_prev <= evt_sync;
        end
    end

    assign evt_rise = evt_sync & ~evt_prev;

    // ------------------------------------------------------------------------
    // symbol error run compression
    // ------------------------------------------------------------------------
    // the first bad symbol of a run counts; each further six make one more
    always @* begin
        next_sym_run = sym_run;
        sym_event    = 1'b0;
        if (!evt_sync[3]) begin
            next_sym_run = `PSCEC_SYM_RUN_ZERO;
        end else if (evt_rise[3] || (sym_run == `PSCEC_SYM_RUN_LEN)) begin
            sym_event    = 1'b1;
            next_sym_run = `PSCEC_SYM_RUN_ONE;
        end else begin
            next_sym_run = sym_run + `PSCEC_SYM_RUN_ONE;
        end
    end

    // ------------------------------------------------------------------------
    // error frame tracking
    // ------------------------------------------------------------------------
    // a frame is marked on its first error and counted only then
    always @* begin
        next_frm_state = frm_state;
        frame_event    = 1'b0;
        case (frm_state)
            FRM_CLEAN: begin
                if (evt_sync[2] && (evt_sync[3] || evt_rise[4])) begin
                    frame_event    = 1'b1;
                    next_frm_state = FRM_MARKED;
                end
            end
            FRM_MARKED: begin
                if (!evt_sync[2]) begin
                    next_frm_state = FRM_CLEAN;
                end
            end
            default: begin
                next_frm_state = FRM_CLEAN;
            end
        endcase
    end

    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            frm_state <= FRM_CLEAN;
            sym_run   <= `PSCEC_SYM_RUN_ZERO;
        end else begin
            frm_state <= next_frm_state;
            sym_run   <= next_sym_run;
        end
    end

    // ------------------------------------------------------------------------
    // disconnect line synchroniser
    // ------------------------------------------------------------------------
    wire disc_sync;
    reg  disc_prev;
    wire disc_rise;

    pscec_sync #(
        .WIDTH (1)
    ) u_sync_disc (
        .clk_sys_in (clk_sys_in),
        .arst_n_in  (arst_n_in),
        .async_in   (disconnect_in),
        .sync_out   (disc_sync)
    );

    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            disc_prev <= 1'b0;
        end else begin
            disc_prev <= disc_sync;
        end
    end

    assign disc_rise = disc_sync & ~disc_prev;

    // ------------------------------------------------------------------------
    // counter events and clears
    // ------------------------------------------------------------------------
    // disconnect has its own synchroniser
    assign cnt_event[CNT_FALSE] = evt_rise[0];
    assign cnt_event[CNT_DISC]  = disc_rise;
    assign cnt_event[CNT_FRAME] = frame_event;
    assign cnt_event[CNT_SYM]   = sym_event;
    assign cnt_event[CNT_PREM]  = evt_rise[4];
    assign cnt_event[CNT_TEN]   = evt_rise[5];
    assign cnt_event[CNT_JAB]   = evt_rise[6];

    // ------------------------------------------------------------------------
    // counter bank
    // ------------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `PSCEC_NUM_COUNTERS; gi = gi + 1) begin : g_cnt
            // a read clears the counter as its value is captured
            assign cnt_clear[gi] = mgmt_rd_in && sel(mgmt_reg_in, cnt_reg(gi));
            pscec_sat_counter #(
                .RESET_VALUE ((gi == CNT_JAB) ? `PSCEC_JABBER_RESET : `PSCEC_CNT_ZERO)
            ) u_cnt (
                .clk_sys_in (clk_sys_in),
                .arst_n_in  (arst_n_in),
                .event_in   (cnt_event[gi]),
                .clear_in   (cnt_clear[gi]),
                .count_out  (cnt_value[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // writable registers
    // ------------------------------------------------------------------------
    // the reserved bit is masked so it always stays zero
    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ctrl      <= `PSCEC_CTRL_RESET;
            equalizer <= `PSCEC_EQ_RESET;
        end else if (mgmt_wr_in) begin
            if (sel(mgmt_reg_in, `PSCEC_REG_CTRL)) begin
                ctrl <= mgmt_wdata_in & `PSCEC_CTRL_WR_MASK;
            end
            if (sel(mgmt_reg_in, `PSCEC_REG_EQUALIZER)) begin
                equalizer <= mgmt_wdata_in;
            end
        end
    end

    // ------------------------------------------------------------------------
    // read multiplexer
    // ------------------------------------------------------------------------
    // unmapped register numbers read as zero
    always @* begin
        case (mgmt_reg_in)
            `PSCEC_REG_CTRL:      next_rdata = ctrl;
            `PSCEC_REG_ADDR:      next_rdata = {`PSCEC_PHY_ADDR_PAD, `PSCEC_PHY_ADDR_VALUE};
            `PSCEC_REG_FALSE_CAR: next_rdata = cnt_value[CNT_FALSE];
            `PSCEC_REG_DISCON:    next_rdata = cnt_value[CNT_DISC];
            `PSCEC_REG_ERR_FRAME: next_rdata = cnt_value[CNT_FRAME];
            `PSCEC_REG_SYM_ERR:   next_rdata = cnt_value[CNT_SYM];
            `PSCEC_REG_PREM_EOF:  next_rdata = cnt_value[CNT_PREM];
            `PSCEC_REG_TEN_EOF:   next_rdata = cnt_value[CNT_TEN];
            `PSCEC_REG_JABBER:    next_rdata = cnt_value[CNT_JAB];
            `PSCEC_REG_EQUALIZER: next_rdata = equalizer;
            default:              next_rdata = `PSCEC_DATA_ZERO;
        endcase
    end

    // ------------------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------------------
    // control outputs are copies of the register so outputs stay flop-driven
    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mgmt_rdata_out             <= `PSCEC_DATA_ZERO;
            mgmt_rvalid_out            <= 1'b0;
            scrambler_bypass_out       <= 1'b0;
            coding_bypass_out          <= 1'b0;
            force_h_pattern_out        <= 1'b0;
            force_34_pattern_out       <= 1'b0;
            force_good_link_out        <= 1'b0;
            tx_crs_disable_out         <= 1'b0;
            dyn_power_down_disable_out <= 1'b0;
            an_loopback_out            <= 1'b0;
            mdi_tristate_out           <= 1'b0;
            filter_bypass_out          <= 1'b0;
            auto_polarity_disable_out  <= 1'b0;
            squelch_disable_out        <= 1'b0;
            ext_squelch_out            <= 1'b0;
            link_integrity_disable_out <= 1'b0;
            jabber_disable_out         <= 1'b0;
            equalizer_ctrl_out         <= `PSCEC_EQ_RESET;
        end else begin
            mgmt_rvalid_out            <= mgmt_rd_in;
            if (mgmt_rd_in) begin
                mgmt_rdata_out <= next_rdata;
            end
            scrambler_bypass_out       <= ctrl[`PSCEC_BIT_SCRAMBLER_BYPASS];
            coding_bypass_out          <= ctrl[`PSCEC_BIT_CODING_BYPASS];
            force_h_pattern_out        <= ctrl[`PSCEC_BIT_FORCE_H_PATTERN];
            force_34_pattern_out       <= ctrl[`PSCEC_BIT_FORCE_34_PATTERN];
            force_good_link_out        <= ctrl[`PSCEC_BIT_GOOD_LINK];
            tx_crs_disable_out         <= ctrl[`PSCEC_BIT_TX_CRS_DISABLE];
            dyn_power_down_disable_out <= ctrl[`PSCEC_BIT_DYN_PD_DISABLE];
            an_loopback_out            <= ctrl[`PSCEC_BIT_AN_LOOPBACK];
            mdi_tristate_out           <= ctrl[`PSCEC_BIT_MDI_TRISTATE];
            filter_bypass_out          <= ctrl[`PSCEC_BIT_FILTER_BYPASS];
            auto_polarity_disable_out  <= ctrl[`PSCEC_BIT_AUTO_POL_DISABLE];
            squelch_disable_out        <= ctrl[`PSCEC_BIT_SQUELCH_DISABLE];
            ext_squelch_out            <= ctrl[`PSCEC_BIT_EXT_SQUELCH];
            link_integrity_disable_out <= ctrl[`PSCEC_BIT_LINK_INT_DISABLE];
            jabber_disable_out         <= ctrl[`PSCEC_BIT_JABBER_DISABLE];
            equalizer_ctrl_out         <= equalizer;
        end
    end
endmodule

// ---- test/pscec_monitor.sv ----
// port checker of the phy special control register bank
`timescale 1ns/100ps
module pscec_monitor (
    input wire        clk_sys_in,
    input wire        arst_n_in,
    input wire        mgmt_rd_in,
    input wire        mgmt_wr_in,
    input wire [4:0]  mgmt_reg_in,
    input wire [15:0] mgmt_wdata_in,
    input wire [15:0] mgmt_rdata_out,
    input wire        mgmt_rvalid_out,
    input wire        scrambler_bypass_out,
    input wire        dyn_power_down_disable_out,
    input wire        mdi_tristate_out,
    input wire        link_integrity_disable_out,
    input wire        jabber_disable_out
);
    // control write strobe: the only cause an output copy may change
    wire ctrl_wr = mgmt_wr_in && (mgmt_reg_in == 5'h11);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!arst_n_in);
    // ------------------------------------------------------------------
    // read side
    // ------------------------------------------------------------------
    AST_PHY_ADDR: assert property (mgmt_rd_in && mgmt_reg_in == 5'h12
        |=> mgmt_rvalid_out && mgmt_rdata_out == 16'h0001)
        else $error("address register read gave a wrong answer");
    AST_RSVD_READ: assert property (mgmt_rd_in && mgmt_reg_in == 5'h11 |=> !mgmt_rdata_out[10])
        else $error("reserved control bit read back as one");
    AST_RVALID_ONLY: assert property (!mgmt_rd_in |=> !mgmt_rvalid_out)
        else $error("read answer without a read request");
    // ------------------------------------------------------------------
    // control copies, two edges after the write
    // ------------------------------------------------------------------
    AST_SCRAMBLER: assert property (ctrl_wr |-> ##2 scrambler_bypass_out == $past(mgmt_wdata_in[15], 2))
        else $error("scrambler bypass copy wrong");
    AST_DYN_PD: assert property (ctrl_wr |-> ##2 dyn_power_down_disable_out == $past(mgmt_wdata_in[8], 2))
        else $error("power-down disable copy wrong");
    AST_LINK_JABBER: assert property (ctrl_wr |-> ##2
        {link_integrity_disable_out, jabber_disable_out} == $past(mgmt_wdata_in[1:0], 2))
        else $error("link or jabber disable copy wrong");
    AST_MDI_SET: assert property (ctrl_wr |-> ##2 mdi_tristate_out == $past(mgmt_wdata_in[6], 2))
        else $error("driver tri-state copy wrong");
    AST_MDI_HOLD: assert property (!ctrl_wr |=> ##1 $stable(mdi_tristate_out))
        else $error("driver tri-state moved without a write");
endmodule
bind pscec_top pscec_monitor u_mon (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
    .mgmt_rd_in(mgmt_rd_in), .mgmt_wr_in(mgmt_wr_in), .mgmt_reg_in(mgmt_reg_in),
    .mgmt_wdata_in(mgmt_wdata_in), .mgmt_rdata_out(mgmt_rdata_out), .mgmt_rvalid_out(mgmt_rvalid_out),
    .scrambler_bypass_out(scrambler_bypass_out), .dyn_power_down_disable_out(dyn_power_down_disable_out),
    .mdi_tristate_out(mdi_tristate_out), .link_integrity_disable_out(link_integrity_disable_out),
    .jabber_disable_out(jabber_disable_out));

// ---- test/pscec_host_model.sv ----
// management controller model issuing register reads and writes
`timescale 1ns/100ps
module pscec_host_model (
    input  wire        clk_sys_in,
    output logic       mgmt_rd_out,
    output logic       mgmt_wr_out,
    output logic [4:0] mgmt_reg_out,
    output logic [15:0] mgmt_wdata_out,
    input  wire [15:0] mgmt_rdata_in,
    input  wire        mgmt_rvalid_in
);
    // idle bus at time zero
    initial begin
        mgmt_rd_out = 1'b0;
        mgmt_wr_out = 1'b0;
        mgmt_reg_out = 5'h00;
        mgmt_wdata_out = 16'h5a5a;
    end
    // one-cycle write; released data shows the inverse so stale data never passes
    task automatic wr(input logic [4:0] r, input logic [15:0] d);
        @(negedge clk_sys_in);
        mgmt_wr_out = 1'b1;
        mgmt_reg_out = r;
        mgmt_wdata_out = d;
        @(negedge clk_sys_in);
        mgmt_wr_out = 1'b0;
        mgmt_wdata_out = ~d;
    endtask
    // the answer stands one cycle after the request edge only
    task automatic rd(input logic [4:0] r, output logic [15:0] d, output logic v);
        @(negedge clk_sys_in);
        mgmt_rd_out = 1'b1;
        mgmt_reg_out = r;
        @(negedge clk_sys_in);
        mgmt_rd_out = 1'b0;
        d = mgmt_rdata_in;
        v = mgmt_rvalid_in;
    endtask
endmodule

// ---- test/pscec_top_bench.sv ----
// self-checking bench of the phy special control register bank
`timescale 1ns/100ps
`include "pscec_consts.vh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_total++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module pscec_top_bench;
    logic        clk_sys_in = 1'b0;
    logic        arst_n_in = 1'b0;
    logic [6:0]  ev = 7'h00;
    wire         rd, wr, rvalid;
    wire  [4:0]  rnum;
    wire  [15:0] wdata, rdata, eq;
    wire  [14:0] ctrl;
    int          err_total = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          cnt[7];
    logic [15:0] d;
    // ------------------------------------------------------------------
    // clock, timeout and instances
    // ------------------------------------------------------------------
    initial begin
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            report_and_stop();
        end
    end
    pscec_host_model u_host (.clk_sys_in(clk_sys_in), .mgmt_rd_out(rd), .mgmt_wr_out(wr), .mgmt_reg_out(rnum),
        .mgmt_wdata_out(wdata), .mgmt_rdata_in(rdata), .mgmt_rvalid_in(rvalid));
    pscec_top u_dut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .mgmt_rd_in(rd), .mgmt_wr_in(wr),
        .mgmt_reg_in(rnum), .mgmt_wdata_in(wdata), .mgmt_rdata_out(rdata), .mgmt_rvalid_out(rvalid),
        .false_carrier_in(ev[0]), .disconnect_in(ev[1]), .rx_frame_active_in(ev[2]), .rx_symbol_error_in(ev[3]),
        .premature_eof_in(ev[4]), .ten_eof_error_in(ev[5]), .jabber_detect_in(ev[6]),
        .scrambler_bypass_out(ctrl[14]), .coding_bypass_out(ctrl[13]), .force_h_pattern_out(ctrl[12]),
        .force_34_pattern_out(ctrl[11]), .force_good_link_out(ctrl[10]), .tx_crs_disable_out(ctrl[9]),
        .dyn_power_down_disable_out(ctrl[8]), .an_loopback_out(ctrl[7]), .mdi_tristate_out(ctrl[6]),
        .filter_bypass_out(ctrl[5]), .auto_polarity_disable_out(ctrl[4]), .squelch_disable_out(ctrl[3]),
        .ext_squelch_out(ctrl[2]), .link_integrity_disable_out(ctrl[1]), .jabber_disable_out(ctrl[0]),
        .equalizer_ctrl_out(eq));
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // control copies skip the reserved bit
    function automatic logic [14:0] exp_ctrl(input logic [15:0] v);
        return {v[15:11], v[9:0]};
    endfunction
    task automatic rd_chk(input logic [4:0] r, input logic [15:0] e);
        logic [15:0] q;
        logic        v;
        u_host.rd(r, q, v);
        `CHK(v, 1'b1)
        `CHK(q, e)
    endtask
    // n level pulses of w cycles, then time for the two-stage sync to drain
    task automatic pulse(input int b, input int n, input int w);
        repeat (n) begin
            @(negedge clk_sys_in);
            ev[b] = 1'b1;
            repeat (w) @(negedge clk_sys_in);
            ev[b] = 1'b0;
            repeat (3) @(negedge clk_sys_in);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32'hd968));
        repeat (8) @(negedge clk_sys_in);
        arst_n_in = 1'b1;
        rd_chk(`PSCEC_REG_CTRL, 16'h0000);
        rd_chk(`PSCEC_REG_ADDR, 16'h0001);
        for (int i = 19; i < 25; i++) rd_chk(5'(i), 16'h0000);
        rd_chk(`PSCEC_REG_JABBER, 16'h0001);
        rd_chk(`PSCEC_REG_JABBER, 16'h0000);
        rd_chk(5'h05, 16'h0000);
        // corner words first, then random control words
        for (int i = 0; i < 8; i++) begin
            d = (i == 0) ? 16'hffff : (i == 1) ? 16'h0400 : 16'($urandom);
            u_host.wr(`PSCEC_REG_CTRL, d);
            @(negedge clk_sys_in);
            `CHK(ctrl, exp_ctrl(d))
            rd_chk(`PSCEC_REG_CTRL, d & 16'hfbff);
        end
        u_host.wr(`PSCEC_REG_ADDR, 16'($urandom));
        rd_chk(`PSCEC_REG_ADDR, 16'h0001);
        d = 16'($urandom);
        u_host.wr(`PSCEC_REG_EQUALIZER, d);
        @(negedge clk_sys_in);
        `CHK(eq, d)
        rd_chk(`PSCEC_REG_EQUALIZER, d);
        // random event counts outside any frame
        foreach (cnt[b]) cnt[b] = 1 + $urandom % 5;
        foreach (cnt[b]) if (b != 2 && b != 3) pulse(b, cnt[b], 2);
        rd_chk(`PSCEC_REG_FALSE_CAR, 16'(cnt[0]));
        rd_chk(`PSCEC_REG_FALSE_CAR, 16'h0000);
        rd_chk(`PSCEC_REG_DISCON, 16'(cnt[1]));
        rd_chk(`PSCEC_REG_PREM_EOF, 16'(cnt[4]));
        rd_chk(`PSCEC_REG_TEN_EOF, 16'(cnt[5]));
        rd_chk(`PSCEC_REG_JABBER, 16'(cnt[6]));
        rd_chk(`PSCEC_REG_ERR_FRAME, 16'h0000);
        // frame one: two short runs, a ten-clock run, an early end; frame two: one run
        ev[2] = 1'b1;
        pulse(3, 2, 2);
        pulse(3, 1, 10);
        pulse(4, 1, 2);
        ev[2] = 1'b0;
        repeat (4) @(negedge clk_sys_in);
        ev[2] = 1'b1;
        pulse(3, 1, 2);
        ev[2] = 1'b0;
        rd_chk(`PSCEC_REG_ERR_FRAME, 16'h0002);
        rd_chk(`PSCEC_REG_SYM_ERR, 16'h0005);
        rd_chk(`PSCEC_REG_PREM_EOF, 16'h0001);
        ev[5] = 1'b1;
        @(negedge clk_sys_in);
        rd_chk(`PSCEC_REG_TEN_EOF, 16'h0000);
        rd_chk(`PSCEC_REG_TEN_EOF, 16'h0001);
        report_and_stop();
    end
endmodule
